// ### design/standby_control_regs.vh
// Offsets of the control and halt status registers; field positions and reset values of the standby control register.
// Assumes inclusion by the standby mode select logic only.
`ifndef STANDBY_CONTROL_REGS_VH
`define STANDBY_CONTROL_REGS_VH
`define ADDR_STANDBY_CONTROL 4'h0
`define ADDR_HALT_STATUS 4'h4
`define BIT_STANDBY_SELECT 15
`define BIT_RSVD_ONE 14
`define BIT_RSVD_ZERO 13
`define WAIT_SEL_MSB 12
`define WAIT_SEL_LSB 8
`define RST_STANDBY_SELECT 1'h0
`define RST_WAIT_SEL 5'h0F
`define RSVD_ONE_VALUE 1'h1
`endif

// ### design/standby_mode_select_control.v
// Standby control register and power-down mode selection on halt.
// Assumes an Avalon-MM master on MCLK_I; halt, wake and watchdog inputs arrive from
// logic on the same clock.
//
// Overview of operation
// RULE1 - Bit 15 of the control register chooses the halt power-down target.
// RULE2 - Standby-select clear: halt enters sleep mode. The code enters all-module-clock-stop instead when ALLSTOP_ENABLE_I is set.
// RULE3 - Standby-select set: halt enters software standby mode.
// RULE4 - Waking from standby by external interrupt leaves standby-select set.
// RULE5 - Software writes 0 to standby-select to return to sleep on halt.
// RULE6 - Watchdog mode forces sleep or all-module-clock-stop, never software standby.
// RULE7 - Bit 14 resets to 1, always reads 1; software writes 1.
// RULE8 - Bit 13 resets to 0 and always reads 0.
// RULE9 - Register is 16-bit read/write; resets select 0, wait field 01111.
// RULE10 - Halted states keep register contents and suspend internal operation.
// RULE11 - Bits 7 to 0 reset to zero and read as zero.
//
// The register addresses and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ps
`include "standby_control_regs.vh"
module standby_mode_select_control (
	input wire MCLK_I,
	input wire RSTN_I,
	input wire [3:0] AVS_ADDRESS_I,
	input wire AVS_READ_I,
	input wire AVS_WRITE_I,
	input wire [31:0] AVS_WRITEDATA_I,
	input wire [3:0] AVS_BYTEENABLE_I,
	output reg [31:0] AVS_READDATA_O,
	output wire AVS_WAITREQUEST_O,
	input wire HALT_EXEC_I,
	input wire WATCHDOG_MODE_I,
	input wire ALLSTOP_ENABLE_I,
	input wire INTERRUPT_I,
	input wire EXT_INTERRUPT_I,
	output reg SLEEP_O,
	output reg ALLSTOP_O,
	output reg STANDBY_O,
	output reg CPU_HOLD_O,
	output reg [4:0] STANDBY_WAIT_SEL_O
);
	// One-hot power states; the status word shows the code as it stands
	localparam [3:0] ST_RUN = 4'h1;
	localparam [3:0] ST_SLEEP = 4'h2;
	localparam [3:0] ST_ALLSTOP = 4'h4;
	localparam [3:0] ST_STANDBY = 4'h8;
	// Map selectors of the address decoder
	localparam [1:0] SEL_NONE = 2'h0;
	localparam [1:0] SEL_CTRL = 2'h1;
	localparam [1:0] SEL_STATUS = 2'h2;

	reg standby_select_reg;
	reg standby_select_next;
	reg [4:0] wait_sel_reg;
	reg [4:0] wait_sel_next;
	reg [3:0] mode_reg;
	reg [3:0] mode_next;
	reg ack_reg;
	reg ack_next;
	reg [31:0] rdata_next;
	reg sleep_next;
	reg allstop_next;
	reg standby_next;
	reg hold_next;
	wire bus_req;
	wire rd_launch;
	wire wr_take;
	wire wr_ctrl;
	wire [15:0] ctrl_word;
	wire [31:0] status_word;
	wire [3:0] halt_mode;

	// Shared by read mux and write strobe, so both see one map
	function [1:0] decode_addr;
		input [3:0] addr;
		case (addr)
		`ADDR_STANDBY_CONTROL: decode_addr = SEL_CTRL;
		`ADDR_HALT_STATUS: decode_addr = SEL_STATUS;
		default: decode_addr = SEL_NONE;
		endcase
	endfunction

	// Standby stops the watchdog, so watchdog mode never picks it
	function [3:0] halt_target;
		input sel_bit;
		input wd_mode;
		input allstop_en;
		if (sel_bit & ~wd_mode) begin
			halt_target = ST_STANDBY; // RULE3
		end else if (allstop_en) begin
			halt_target = ST_ALLSTOP; // RULE6
		end else begin
			halt_target = ST_SLEEP; // RULE2
		end
	endfunction

	// Fixed single wait state, so read data can come from a flip-flop
	assign bus_req = AVS_READ_I | AVS_WRITE_I;
	assign AVS_WAITREQUEST_O = bus_req & ~ack_reg;
	assign rd_launch = AVS_READ_I & ~ack_reg;
	assign wr_take = AVS_WRITE_I & ack_reg;
	assign wr_ctrl = wr_take & AVS_BYTEENABLE_I[1] & (decode_addr(AVS_ADDRESS_I) == SEL_CTRL);
	// Bits 13 and 7..0 not stored, so no write can make them read other than zero
	assign ctrl_word = {standby_select_reg, `RSVD_ONE_VALUE, 1'h0, wait_sel_reg, 8'h00}; // RULE7 RULE8 RULE11
	assign status_word = {28'h0000000, mode_reg};
	assign halt_mode = halt_target(standby_select_reg, WATCHDOG_MODE_I, ALLSTOP_ENABLE_I); // RULE1 RULE6

	always @* begin
		ack_next = bus_req & ~ack_reg;
		rdata_next = AVS_READDATA_O;
		if (rd_launch) begin
			case (decode_addr(AVS_ADDRESS_I))
			SEL_CTRL: begin
				rdata_next = {16'h0000, ctrl_word}; // RULE9
			end
			SEL_STATUS: begin
				rdata_next = status_word;
			end
			default: begin
				rdata_next = 32'h00000000;
			end
			endcase
		end
	end

	always @(posedge MCLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			ack_reg <= 1'h0;
			AVS_READDATA_O <= 32'h00000000;
		end else begin
			ack_reg <= ack_next;
			AVS_READDATA_O <= rdata_next;
		end
	end

	// Only a bus write moves these; halt and wake never touch them
	always @* begin
		standby_select_next = standby_select_reg; // RULE4 RULE10
		wait_sel_next = wait_sel_reg;
		if (wr_ctrl) begin
			standby_select_next = AVS_WRITEDATA_I[`BIT_STANDBY_SELECT]; // RULE5
			wait_sel_next = AVS_WRITEDATA_I[`WAIT_SEL_MSB:`WAIT_SEL_LSB];
		end
	end

	always @(posedge MCLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			standby_select_reg <= `RST_STANDBY_SELECT; // RULE9
			wait_sel_reg <= `RST_WAIT_SEL; // RULE9
		end else begin
			standby_select_reg <= standby_select_next;
			wait_sel_reg <= wait_sel_next;
		end
	end

	always @* begin
		mode_next = mode_reg;
		case (mode_reg)
		ST_RUN: begin
			if (HALT_EXEC_I) begin
				mode_next = halt_mode; // RULE1
			end
		end
		ST_SLEEP: begin
			if (INTERRUPT_I) begin
				mode_next = ST_RUN;
			end
		end
		ST_ALLSTOP: begin
			if (INTERRUPT_I) begin
				mode_next = ST_RUN;
			end
		end
		ST_STANDBY: begin
			// Oscillator is down here, so only the external wake counts
			if (EXT_INTERRUPT_I) begin
				mode_next = ST_RUN; // RULE4
			end
		end
		default: begin
			mode_next = ST_RUN;
		end
		endcase
	end

	always @* begin
		sleep_next = (mode_next == ST_SLEEP);
		allstop_next = (mode_next == ST_ALLSTOP);
		standby_next = (mode_next == ST_STANDBY);
		hold_next = (mode_next != ST_RUN); // RULE10
	end

	always @(posedge MCLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			mode_reg <= ST_RUN;
			SLEEP_O <= 1'h0;
			ALLSTOP_O <= 1'h0;
			STANDBY_O <= 1'h0;
			CPU_HOLD_O <= 1'h0;
		end else begin
			mode_reg <= mode_next;
			SLEEP_O <= sleep_next;
			ALLSTOP_O <= allstop_next;
			STANDBY_O <= standby_next;
			CPU_HOLD_O <= hold_next;
		end
	end

	// Copy lags the register by one cycle; the field is only exported
	always @(posedge MCLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			STANDBY_WAIT_SEL_O <= `RST_WAIT_SEL;
		end else begin
			STANDBY_WAIT_SEL_O <= wait_sel_reg;
		end
	end
endmodule

// ### verif/standby_checker_asserts.sv
// Port checker of the standby control block.
// Assumes a bind onto the top module.
`timescale 1ns/1ps
module standby_checker(input wire MCLK_I,RSTN_I,input wire [3:0] AVS_ADDRESS_I,
	input wire AVS_READ_I,AVS_WRITE_I,AVS_WAITREQUEST_O,HALT_EXEC_I,WATCHDOG_MODE_I,
	input wire INTERRUPT_I,SLEEP_O,ALLSTOP_O,STANDBY_O,CPU_HOLD_O,
	input wire [31:0] AVS_READDATA_O,input wire [4:0] STANDBY_WAIT_SEL_O);
default clocking @(posedge MCLK_I); endclocking
default disable iff (!RSTN_I);
wire rq=AVS_READ_I|AVS_WRITE_I;
sequence s_halt; HALT_EXEC_I && !CPU_HOLD_O; endsequence
sequence s_rd; AVS_READ_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I==4'h0; endsequence
property p_w; $rose(rq) |-> AVS_WAITREQUEST_O; endproperty
property p_a; rq && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O; endproperty
property p_s; s_halt ##0 WATCHDOG_MODE_I |=> CPU_HOLD_O && !STANDBY_O; endproperty
property p_h; CPU_HOLD_O==(SLEEP_O|ALLSTOP_O|STANDBY_O); endproperty
property p_1; $onehot0({SLEEP_O,ALLSTOP_O,STANDBY_O}); endproperty
property p_r; s_rd |-> AVS_READDATA_O[14:13]==2'h2 && AVS_READDATA_O[7:0]==8'h00; endproperty
property p_t; s_rd |-> AVS_READDATA_O[12:8]==STANDBY_WAIT_SEL_O; endproperty
property p_k; CPU_HOLD_O && !STANDBY_O && INTERRUPT_I |=> !CPU_HOLD_O; endproperty
a_w: assert property(p_w) else $error("no wait");
a_a: assert property(p_a) else $error("late answer");
a_s: assert property(p_s) else $error("watchdog standby");
a_h: assert property(p_h) else $error("hold mismatch");
a_1: assert property(p_1) else $error("two modes");
a_r: assert property(p_r) else $error("reserved bits");
a_t: assert property(p_t) else $error("wait field");
a_k: assert property(p_k) else $error("no wake");
endmodule

// ### verif/tb_standby_mode_select_control.sv
// Bench of the standby register and halt mode outputs.
// Assumes the checker file is compiled first.
`timescale 1ns/1ps
module tb_standby_mode_select_control;
reg c=0,r=0,rd=0,wr=0,h=0,wd=0,ae=0,it=0,ei=0;
reg [3:0] a=0,be=4'hF;
reg [31:0] d=0,o;
reg [4:0] ws=5'h0F;
reg sel=0;
integer n_mismatch=0,checked=0,seed=3,i,rv;
wire [31:0] q;
wire w,sl,al,sb,ch;
wire [4:0] wso;
standby_mode_select_control dut(.MCLK_I(c),.RSTN_I(r),.AVS_ADDRESS_I(a),.AVS_READ_I(rd),
	.AVS_WRITE_I(wr),.AVS_WRITEDATA_I(d),.AVS_BYTEENABLE_I(be),.AVS_READDATA_O(q),
	.AVS_WAITREQUEST_O(w),.HALT_EXEC_I(h),.WATCHDOG_MODE_I(wd),.ALLSTOP_ENABLE_I(ae),
	.INTERRUPT_I(it),.EXT_INTERRUPT_I(ei),.SLEEP_O(sl),.ALLSTOP_O(al),.STANDBY_O(sb),
	.CPU_HOLD_O(ch),.STANDBY_WAIT_SEL_O(wso));
always #20 c=~c;
task test_done; begin
	$display("mismatches %0d checked %0d",n_mismatch,checked);
	if (n_mismatch==0 && checked>0) $display("ALL TESTS PASSED");
	else $display("TESTS FAILED");
	$finish;
end endtask
task chk(input [31:0] s,e); begin
	checked=checked+1;
	if (s!==e) begin n_mismatch=n_mismatch+1; $display("wrong value %0t %h %h",$time,s,e); end
end endtask
task bus(input x,input [3:0] ad,input [31:0] v); integer k; begin
	@(posedge c); rd<=!x; wr<=x; a<=ad; d<=v; k=0;
	do begin @(posedge c); k=k+1; if (k>20) begin n_mismatch=n_mismatch+1; test_done; end
	end while (w!==1'b0);
	o=q; rd<=0; wr<=0;
end endtask
task rdc; begin
	bus(0,4'h0,0);
	chk(o,{16'h0000,sel,2'h2,ws,8'h00});
	chk(wso,ws);
end endtask
// Byte lane 1 carries every stored bit
task wrc(input [31:0] v); begin
	bus(1,4'h0,v);
	if (be[1]) begin
		sel=v[15];
		ws=v[12:8];
	end
end endtask
// Both wakes raised together so every mode clears
task hl(input wg,input en,input [2:0] e); begin
	@(posedge c); wd<=wg; ae<=en; h<=1; @(posedge c); h<=0; #1 chk({sl,al,sb},e);
	bus(0,4'h4,0);
	chk(o,{28'h0000000,e[0],e[1],e[2],1'h0});
	@(posedge c); it<=1; ei<=1; @(posedge c); it<=0; ei<=0; #1 chk(ch,0);
end endtask
initial begin
	repeat (20) @(posedge c);
	r<=1;
	rdc;
	// Reserved bits written as software must write them; random lane enables
	for (i=0;i<6;i=i+1) begin
		rv=$random(seed);
		be<=rv[3:0];
		wrc(($random(seed) & 32'hFFFF9F00) | 32'h00004000);
		rdc;
	end
	be<=4'hF;
	bus(0,4'h8,0); chk(o,0);
	bus(0,4'h4,0); chk(o,32'h00000001);
	$display("register test done");
	wrc(32'h4000); hl(0,0,3'h4);
	wrc(32'hC000); hl(0,0,3'h1); rdc;
	hl(1,0,3'h4); hl(1,1,3'h2);
	wrc(32'h4F00); hl(0,0,3'h4);
	$display("halt test done");
	// Mid-run reset must bring back the reset image over written values
	wrc(32'h0000C000);
	r<=0;
	repeat (2) @(posedge c);
	r<=1;
	sel=0;
	ws=5'h0F;
	rdc;
	$display("reset test done");
	test_done;
end
endmodule
bind standby_mode_select_control standby_checker u_chk(.*);
